/* File: pkg/sbc_defs.svh */
// register map, field positions, reset values and counts of the serial baud control block
`ifndef SBC_DEFS_SVH
`define SBC_DEFS_SVH
// byte offsets on the register bus
`define SBC_OFS_BAUD_CTRL 8'h00
`define SBC_OFS_DIV_LO 8'h04
`define SBC_OFS_DIV_HI 8'h08
`define SBC_OFS_MODE 8'h0c
// baud_control field positions
`define SBC_BIT_AUTO_RATE 0
`define SBC_BIT_WAKE 1
`define SBC_BIT_WIDE 3
`define SBC_BIT_POL 4
`define SBC_BIT_RX_IDLE 6
// mode register field position
`define SBC_BIT_SYNC 0
// reset values
`define SBC_RST_CTRL 8'h00
`define SBC_RST_DIV 16'h0000
`define SBC_RST_BYTE 8'h00
// sync character measurement: falling edges after the start edge, and
// right shift from eight bit times to one sixteenth of a bit time
`define SBC_ABD_EDGES 3'h4
`define SBC_ABD_SHIFT 7
`define SBC_ABD_CNT_W 24
`define SBC_ABD_CNT_MAX 24'hffffff
`define SBC_ABD_CNT_ONE 24'h000001
`define SBC_ABD_CNT_ZERO 24'h000000
`define SBC_DIV_ONE 16'h0001
`define SBC_DIV_ZERO 16'h0000
`define SBC_EDGE_ONE 3'h1
`define SBC_EDGE_ZERO 3'h0
`endif

/* File: pkg/sbc_pkg.sv */
// types of the serial baud control block
package sbc_pkg;
  // auto-rate measurement sequencer states
  typedef enum logic [0:0] {
    SBC_ABD_IDLE,
    SBC_ABD_MEASURE
  } sbc_abd_state_t;
endpackage : sbc_pkg

/* File: rtl/sbc_brg.sv */
// baud rate generator counter, 8-bit or 16-bit wide
`timescale 1ns/1ps
`include "sbc_defs.svh"
module sbc_brg (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic wide_i,
  input wire logic [15:0] div_i,
  output logic tick_o
);
  logic [15:0] cnt_q; // down counter, reloaded from the divider
  logic [15:0] reload; // divider value seen through the chosen width

  // in narrow mode the high byte is ignored entirely, so a stale high byte cannot stretch the period
  always_comb begin
    reload = wide_i ? div_i : {8'h00, div_i[7:0]};
  end

  // count down and emit a one-cycle tick on wrap; period is reload+1 clocks
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cnt_q <= `SBC_RST_DIV;
      tick_o <= 1'b0;
    end else if (cnt_q == `SBC_DIV_ZERO) begin
      cnt_q <= reload;
      tick_o <= 1'b1;
    end else begin
      // a shrink of the divider takes effect at once rather than after a wrap
      cnt_q <= (cnt_q > reload) ? reload : cnt_q - `SBC_DIV_ONE;
      tick_o <= 1'b0;
    end
  end
endmodule : sbc_brg

/* File: rtl/sbc_top.sv */
// baud control register block: idle polarity, divider width, wake on edge, auto-rate detection
//
// Decided for this implementation: the address map and register access over Wishbone.
`timescale 1ns/1ps
`include "sbc_defs.svh"
module sbc_top (
  input wire logic mclk_i,
  input wire logic rst_i,
  // classic wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // serial side
  input wire logic rx_i,
  input wire logic rx_busy_i,
  output logic tx_idle_level_o,
  output logic ck_idle_level_o,
  output logic sync_mode_o,
  output logic wide_divider_o,
  output logic baud_tick_o,
  output logic wake_irq_o
);
  // control bits
  logic idle_polarity_select_q; // shared polarity bit
  logic wide_divider_select_q; // divider width
  logic wake_on_rx_edge_q; // wake monitor armed
  logic auto_rate_detect_q; // measurement armed or running
  logic sync_mode_q; // 1 = synchronous mode
  logic [15:0] div_q; // baud divider
  // receive pin history
  logic rx_prev_q; // rx one cycle ago
  logic rx_fall; // falling edge seen this cycle
  logic rx_rise; // rising edge seen this cycle
  logic wake_armed_q; // falling edge taken, waiting for the rising one
  // measurement
  sbc_pkg::sbc_abd_state_t abd_state_q;
  logic [`SBC_ABD_CNT_W-1:0] abd_cnt_q; // clocks since the start edge
  logic [2:0] abd_edges_q; // falling edges after the start edge
  logic abd_done; // last falling edge of the sync character
  logic [`SBC_ABD_CNT_W-1:0] abd_scaled; // count reduced to one tick period
  // bus decode
  logic bus_req; // a fresh request this cycle
  logic wr_byte; // write strobe on the low byte lane
  logic rx_idle_flag; // read view of the receiver state
  logic [7:0] ctrl_view; // read view of baud_control

  // a request is answered exactly once; ack drops in the cycle after it was given
  always_comb begin
    bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wr_byte = bus_req & wb_we_i & wb_sel_i[0];
  end

  // edges of the receive pin, which arrives synchronous to mclk
  always_comb begin
    rx_fall = rx_prev_q & ~rx_i;
    rx_rise = ~rx_prev_q & rx_i;
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rx_prev_q <= 1'b1;
    end else begin
      rx_prev_q <= rx_i;
    end
  end

  // idle flag only means something in async mode; in sync mode it simply reads as idle
  always_comb begin
    rx_idle_flag = sync_mode_q | ~rx_busy_i;
  end

  // baud_control read image; bits five, two and seven are not implemented
  always_comb begin
    ctrl_view = 8'h00;
    ctrl_view[`SBC_BIT_AUTO_RATE] = auto_rate_detect_q;
    ctrl_view[`SBC_BIT_WAKE] = wake_on_rx_edge_q;
    ctrl_view[`SBC_BIT_WIDE] = wide_divider_select_q;
    ctrl_view[`SBC_BIT_POL] = idle_polarity_select_q;
    ctrl_view[`SBC_BIT_RX_IDLE] = rx_idle_flag;
  end

  // plain software-owned control bits
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      idle_polarity_select_q <= 1'b0;
      wide_divider_select_q <= 1'b0;
      sync_mode_q <= 1'b0;
    end else if (wr_byte) begin
      if (wb_adr_i == `SBC_OFS_BAUD_CTRL) begin
        idle_polarity_select_q <= wb_dat_i[`SBC_BIT_POL];
        wide_divider_select_q <= wb_dat_i[`SBC_BIT_WIDE];
      end
      if (wb_adr_i == `SBC_OFS_MODE) begin
        sync_mode_q <= wb_dat_i[`SBC_BIT_SYNC];
      end
    end
  end

  // wake monitor: software write wins over the hardware clear in the same cycle
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      wake_on_rx_edge_q <= 1'b0;
      wake_armed_q <= 1'b0;
      wake_irq_o <= 1'b0;
    end else begin
      wake_irq_o <= 1'b0;
      if (wake_on_rx_edge_q & ~sync_mode_q) begin
        if (rx_fall & ~wake_armed_q) begin
          wake_irq_o <= 1'b1;
          wake_armed_q <= 1'b1;
        end else if (rx_rise & wake_armed_q) begin
          wake_on_rx_edge_q <= 1'b0;
          wake_armed_q <= 1'b0;
        end
      end else begin
        // disarmed or sync mode: the pin is not watched at all
        wake_armed_q <= 1'b0;
      end
      if (wr_byte && wb_adr_i == `SBC_OFS_BAUD_CTRL) begin
        wake_on_rx_edge_q <= wb_dat_i[`SBC_BIT_WAKE];
        if (!wb_dat_i[`SBC_BIT_WAKE]) begin
          wake_armed_q <= 1'b0;
        end
      end
    end
  end

  // the sync character has falling edges at bit times 0, 2, 4, 6 and 8
  always_comb begin
    abd_done = (abd_state_q == sbc_pkg::SBC_ABD_MEASURE) & rx_fall &
               (abd_edges_q == `SBC_ABD_EDGES - `SBC_EDGE_ONE);
    abd_scaled = abd_cnt_q >> `SBC_ABD_SHIFT;
  end

  // measurement sequencer; the count saturates so a stuck line cannot wrap to a tiny divider
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      abd_state_q <= sbc_pkg::SBC_ABD_IDLE;
      abd_cnt_q <= `SBC_ABD_CNT_ZERO;
      abd_edges_q <= `SBC_EDGE_ZERO;
    end else if (!auto_rate_detect_q || sync_mode_q) begin
      abd_state_q <= sbc_pkg::SBC_ABD_IDLE;
    end else begin
      case (abd_state_q)
        sbc_pkg::SBC_ABD_IDLE: begin
          if (rx_fall) begin
            abd_state_q <= sbc_pkg::SBC_ABD_MEASURE;
            abd_cnt_q <= `SBC_ABD_CNT_ONE;
            abd_edges_q <= `SBC_EDGE_ZERO;
          end
        end
        sbc_pkg::SBC_ABD_MEASURE: begin
          if (abd_cnt_q != `SBC_ABD_CNT_MAX) begin
            abd_cnt_q <= abd_cnt_q + `SBC_ABD_CNT_ONE;
          end
          if (abd_done) begin
            abd_state_q <= sbc_pkg::SBC_ABD_IDLE;
          end else if (rx_fall) begin
            abd_edges_q <= abd_edges_q + `SBC_EDGE_ONE;
          end
        end
        default: begin
          abd_state_q <= sbc_pkg::SBC_ABD_IDLE;
        end
      endcase
    end
  end

  // auto-rate bit: software write wins over the completion clear
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      auto_rate_detect_q <= 1'b0;
    end else if (wr_byte && wb_adr_i == `SBC_OFS_BAUD_CTRL) begin
      auto_rate_detect_q <= wb_dat_i[`SBC_BIT_AUTO_RATE];
    end else if (abd_done) begin
      auto_rate_detect_q <= 1'b0;
    end
  end

  // divider: written by software or loaded with the measured value
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      div_q <= `SBC_RST_DIV;
    end else if (wr_byte && wb_adr_i == `SBC_OFS_DIV_LO) begin
      div_q[7:0] <= wb_dat_i[7:0];
    end else if (wr_byte && wb_adr_i == `SBC_OFS_DIV_HI) begin
      div_q[15:8] <= wb_dat_i[7:0];
    end else if (abd_done) begin
      // too slow a line for the divider saturates it rather than wrapping
      if (abd_scaled[`SBC_ABD_CNT_W-1:16] != 8'h00) begin
        div_q <= 16'hffff;
      end else if (abd_scaled[15:0] == `SBC_DIV_ZERO) begin
        div_q <= `SBC_DIV_ZERO;
      end else begin
        div_q <= abd_scaled[15:0] - `SBC_DIV_ONE;
      end
    end
  end

  // line idle levels are registered so the pins never glitch on a bus write
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      tx_idle_level_o <= 1'b1;
      ck_idle_level_o <= 1'b0;
      sync_mode_o <= 1'b0;
      wide_divider_o <= 1'b0;
    end else begin
      tx_idle_level_o <= ~idle_polarity_select_q;
      ck_idle_level_o <= idle_polarity_select_q;
      sync_mode_o <= sync_mode_q;
      wide_divider_o <= wide_divider_select_q;
    end
  end

  // bus answer: one wait-free cycle, unmapped addresses read zero and ignore writes
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req) begin
        case (wb_adr_i)
          `SBC_OFS_BAUD_CTRL: wb_dat_o <= {24'h000000, ctrl_view};
          `SBC_OFS_DIV_LO: wb_dat_o <= {24'h000000, div_q[7:0]};
          `SBC_OFS_DIV_HI: wb_dat_o <= {24'h000000, div_q[15:8]};
          `SBC_OFS_MODE: wb_dat_o <= {31'h00000000, sync_mode_q};
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

  // baud generator follows the width bit directly
  sbc_brg u_brg (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .wide_i(wide_divider_select_q),
    .div_i(div_q),
    .tick_o(baud_tick_o)
  );
endmodule : sbc_top

/* File: test/sbc_node.sv */
// remote serial node model: sends one 55h character on the receive line
`timescale 1ns/1ps
module sbc_node #(
  parameter int BIT_CLKS = 32
) (
  input wire logic mclk_i,
  input wire logic go_i,
  output logic rx_o,
  output logic busy_o
);
  // start bit, 55h lsb first, stop bit
  localparam logic [9:0] FRAME = {1'b1, 8'h55, 1'b0};
  int n_q; // clocks left in the frame
  initial begin
    rx_o = 1'b1;
    busy_o = 1'b0;
    n_q = 0;
  end
  // line is driven high between frames; busy mirrors the receiver
  always @(posedge mclk_i) begin
    if (n_q == 0) begin
      rx_o <= 1'b1;
      busy_o <= 1'b0;
      if (go_i) n_q <= 10 * BIT_CLKS;
    end else begin
      rx_o <= FRAME[(10 * BIT_CLKS - n_q) / BIT_CLKS];
      busy_o <= 1'b1;
      n_q <= n_q - 1;
    end
  end
endmodule : sbc_node

/* File: test/sbc_top_checker.sv */
// port assertions of the serial baud control block
`timescale 1ns/1ps
`include "sbc_defs.svh"
module sbc_top_checker (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic rx_i,
  input wire logic rx_busy_i,
  input wire logic tx_idle_level_o,
  input wire logic ck_idle_level_o,
  input wire logic sync_mode_o,
  input wire logic wake_irq_o
);
  // single clock domain
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // a read answer from the control register
  wire rd_ctrl = wb_ack_o && !wb_we_i && wb_adr_i == `SBC_OFS_BAUD_CTRL;
  chk_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  chk_idle_levels: assert property (tx_idle_level_o == !ck_idle_level_o) else $error("idle levels");
  chk_unused_zero: assert property (rd_ctrl |-> !wb_dat_o[7] && !wb_dat_o[5] && !wb_dat_o[2])
    else $error("unused bits set");
  // busy held steady so the sampled flag is unambiguous
  chk_rx_idle: assert property (rd_ctrl && !sync_mode_o && $stable(rx_busy_i) |-> wb_dat_o[6] == !rx_busy_i)
    else $error("idle flag wrong");
  chk_irq_pulse: assert property (wake_irq_o |=> !wake_irq_o) else $error("irq too long");
  chk_irq_fall: assert property (wake_irq_o |-> !$past(rx_i) && $past(rx_i, 2)) else $error("irq w/o fall");
  // the pin levels must agree with the polarity bit that software reads back
  chk_tx_pol_read: assert property (rd_ctrl |-> tx_idle_level_o == !wb_dat_o[`SBC_BIT_POL])
    else $error("tx idle level disagrees with polarity");
  chk_ck_pol_read: assert property (rd_ctrl |-> ck_idle_level_o == wb_dat_o[`SBC_BIT_POL])
    else $error("clock idle level disagrees with polarity");
  chk_irq_async: assert property (wake_irq_o |-> !sync_mode_o) else $error("irq in sync");
endmodule : sbc_top_checker
bind sbc_top sbc_top_checker u_sbc_top_checker (.mclk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_dat_o, .wb_ack_o, .rx_i, .rx_busy_i, .tx_idle_level_o, .ck_idle_level_o, .sync_mode_o, .wake_irq_o);

/* File: test/sbc_top_tb.sv */
// self-checking bench of the serial baud control block
`timescale 1ns/1ps
`include "sbc_defs.svh"
module sbc_top_tb;
  localparam int B = 32; // clocks per bit of the remote node
  logic mclk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, go = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0, rd;
  logic [3:0] sel = 4'h1;
  logic rx, busy, tx_idle, ck_idle, sync_m, wide, tick, irq;
  logic [31:0] wb_dat;
  logic wb_ack;
  logic [7:0] v, lo, hi;
  int errors = 0, n_tests = 0, irq_n = 0, p;
  always #2.5 mclk_i = ~mclk_i;
  sbc_top u_sbc_top (.mclk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat), .wb_ack_o(wb_ack), .rx_i(rx), .rx_busy_i(busy),
    .tx_idle_level_o(tx_idle), .ck_idle_level_o(ck_idle), .sync_mode_o(sync_m), .wide_divider_o(wide),
    .baud_tick_o(tick), .wake_irq_o(irq));
  sbc_node #(.BIT_CLKS(B)) u_sbc_node (.mclk_i, .go_i(go), .rx_o(rx), .busy_o(busy));
  // interrupt pulses, counted per scenario
  always @(posedge mclk_i) if (irq === 1'b1) irq_n++;
  // expected control readback: unused bits zero, idle flag from receiver state
  function automatic logic [31:0] exp_ctrl(input logic [7:0] w, input logic b);
    return {24'h0, 1'b0, !b, 1'b0, w[4], w[3], 1'b0, w[1], w[0]};
  endfunction : exp_ctrl
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // classic cycle: hold everything until ack is sampled high, wait is bounded
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int t;
    t = 0;
    @(posedge mclk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h0, d};
    do begin
      @(posedge mclk_i);
      t++;
    end while (wb_ack !== 1'b1 && t < 50);
    rd = wb_dat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (t >= 50) chk("ack", 1, 0);
  endtask : wb
  // clocks between two baud ticks, bounded
  task automatic period();
    p = 0;
    do @(posedge mclk_i); while (tick !== 1'b1 && ++p < 2000);
    p = 0;
    do begin
      @(posedge mclk_i);
      p++;
    end while (tick !== 1'b1 && p < 2000);
  endtask : period
  // one frame from the remote node, then wait lead clocks, which may end before the line is idle again
  task automatic frame(input int lead);
    @(posedge mclk_i); go <= 1'b1;
    @(posedge mclk_i); go <= 1'b0;
    repeat (lead) @(posedge mclk_i);
  endtask : frame
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test
  // cuts a hang short: the run needs well under 20000 clocks
  initial begin
    #200000;
    errors++;
    end_of_test();
  end
  initial begin
    void'($urandom(32'h0589a4c5));
    repeat (16) @(posedge mclk_i);
    rst_i <= 1'b0;
    wb(0, `SBC_OFS_BAUD_CTRL, 8'h00);
    chk("ctrl reset", exp_ctrl(8'h00, 0), rd);
    chk("tx idle reset", 1, tx_idle);
    // random polarity, width and divider; wake and auto-rate kept off here
    repeat (4) begin
      v = 8'($urandom()) & 8'hfc;
      lo = 8'($urandom());
      hi = 8'($urandom()) & 8'h03;
      wb(1, `SBC_OFS_BAUD_CTRL, v);
      wb(1, `SBC_OFS_DIV_LO, lo);
      wb(1, `SBC_OFS_DIV_HI, hi);
      wb(0, `SBC_OFS_BAUD_CTRL, 8'h00);
      chk("ctrl", exp_ctrl(v & 8'h18, 0), rd);
      chk("tx idle", !v[4], tx_idle);
      chk("wide", v[3], wide);
      period();
      chk("period", v[3] ? {hi, lo} + 1 : lo + 1, p);
    end
    // unmapped place: write dropped, read zero
    wb(1, 8'h10, 8'hff);
    wb(0, 8'h10, 8'h00);
    chk("unmapped", 0, rd);
    // wake armed: one interrupt, bit cleared by the following rise
    wb(1, `SBC_OFS_BAUD_CTRL, 8'h02);
    irq_n = 0;
    frame(10 * B + 4);
    chk("wake irq", 1, irq_n);
    wb(0, `SBC_OFS_BAUD_CTRL, 8'h00);
    chk("wake clear", exp_ctrl(8'h00, 0), rd);
    // wake off: falling edges raise nothing
    wb(1, `SBC_OFS_BAUD_CTRL, 8'h00);
    irq_n = 0;
    frame(10 * B + 4);
    chk("no wake", 0, irq_n);
    // auto-rate on a 55h: 8 bits of B clocks give divider (8B >> 7) - 1
    wb(1, `SBC_OFS_BAUD_CTRL, 8'h01);
    frame(20);
    wb(0, `SBC_OFS_BAUD_CTRL, 8'h00);
    chk("measuring", exp_ctrl(8'h01, 1), rd);
    repeat (10 * B) @(posedge mclk_i);
    wb(0, `SBC_OFS_BAUD_CTRL, 8'h00);
    chk("rate done", exp_ctrl(8'h00, 0), rd);
    period();
    chk("rate period", (8 * B >> 7), p);
    // synchronous mode: polarity drives the clock idle level, wake is ignored
    wb(1, `SBC_OFS_MODE, 8'h01);
    wb(1, `SBC_OFS_BAUD_CTRL, 8'h12);
    irq_n = 0;
    // the frame also gives the registered idle levels time to settle
    frame(10 * B + 4);
    chk("sync", 1, sync_m);
    chk("ck idle", 1, ck_idle);
    chk("sync no wake", 0, irq_n);
    wb(1, `SBC_OFS_BAUD_CTRL, 8'h00);
    // idle levels are registered one edge behind the control bit
    repeat (2) @(posedge mclk_i);
    chk("ck idle low", 0, ck_idle);
    chk("tx idle high", 1, tx_idle);
    end_of_test();
  end
endmodule : sbc_top_tb
